//--- rtl/eic_ctrl.sv
// Integration controller: modes, start/stop, polarity sums
`timescale 1ns/1ps
// How it works
// - Manual: start, stop at time/value ceiling
// - Manual stop freezes time and value
// - Standard: stop at preset or ceiling, hold
// - Continuous: clear and restart each preset
// - Continuous: value ceiling stops and holds
// - Scheduled standard: start/stop at calendar times
// - Scheduled standard: nonzero preset also stops
// - Scheduled repeat: restart each preset, stop scheduled
// - Refuse start/stop during harmonic analysis
// - Manual start from key or remote
// - Refuse rate change while running
// - Refuse start at fastest rate
// - Sum sample products, DC current samples
// - RMS/mean: sum per-update current
// - Separate positive and negative energy sums
// - Separate positive and negative DC charge
// - Digit cursor wraps both ways
// - Zero preset refuses scheduled repeat start
// - Preset clamped to hour/minute maximum
// - Stop earlier than start is refused
module eic_ctrl
  import eic_pkg::*;
#(
  parameter int SEC_CNT = SEC_CYCLES
) (
  input  wire logic        i_mclk,             // 40 MHz clock
  input  wire logic        i_rst_n,            // Async reset, active low
  input  wire logic        i_start_key,        // Start key pulse
  input  wire logic        i_start_cmd,        // Remote start pulse
  input  wire logic        i_stop_req,         // Stop key or remote stop pulse
  input  wire logic        i_reset_cmd,        // Integration reset pulse
  input  wire eic_mode_t   i_mode,             // Integration mode
  input  wire eic_preset_t i_preset,           // Timer preset
  input  wire logic [31:0] i_rtc_now,          // Calendar time, seconds
  input  wire logic [31:0] i_sched_start,      // Scheduled start
  input  wire logic [31:0] i_sched_stop,       // Scheduled stop
  input  wire logic        i_harm_active,      // Harmonic analysis running
  input  wire logic [1:0]  i_rate_sel,         // Update rate setting
  input  wire logic        i_rate_change_req,  // Rate change attempt pulse
  input  wire eic_sample_t i_sample,           // Instantaneous sample
  input  wire eic_cmode_t  i_cmode,            // Current measurement mode
  input  wire logic        i_update_valid,     // Update cycle strobe
  input  wire logic [15:0] i_curr_meas,        // Current per update cycle
  input  wire logic        i_cur_left,         // Cursor left key
  input  wire logic        i_cur_right,        // Cursor right key
  output logic             o_running,          // Accumulating
  output logic             o_holding,          // Holding results
  output logic             o_armed,            // Waiting for scheduled start
  output logic             o_rate_locked,      // Rate changes refused
  output eic_time_t        o_elapsed,          // Elapsed time
  output eic_preset_t      o_preset,           // Preset in force
  output logic [47:0]      o_pos_energy_total, // Both positive energy
  output logic [47:0]      o_neg_energy_total, // Both negative energy
  output logic [47:0]      o_pos_charge_total, // Positive charge
  output logic [47:0]      o_neg_charge_total, // Negative charge
  output eic_err_t         o_err,              // Error pulses
  output logic [2:0]       o_cursor            // Edit cursor digit
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN, ST_HOLD} eic_state_t;

  eic_state_t  st_q;
  eic_state_t  st_d;
  eic_preset_t preset_q;
  eic_preset_t preset_d;
  eic_err_t    err_q;
  eic_err_t    err_d;
  logic [ACC_W-1:0] acc_q   [NUM_SUMS];
  logic [ACC_W-1:0] add_val [NUM_SUMS];
  logic             add_en  [NUM_SUMS];
  eic_time_t   elapsed;
  logic        run_q;
  logic        hold_q;
  logic        armed_q;

  // ----------------------------------------------------------------
  // Preset clamp
  // ----------------------------------------------------------------
  assign preset_d.hours = (i_preset.hours > HOURS_MAX) ? HOURS_MAX : i_preset.hours;
  assign preset_d.mins  = (i_preset.mins > MINS_MAX) ? MINS_MAX : i_preset.mins;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire is_manual  = (i_mode == EIC_MANUAL);
  wire is_rt      = (i_mode == EIC_RT_STD) || (i_mode == EIC_RT_CONT);
  wire is_repeat  = (i_mode == EIC_CONT) || (i_mode == EIC_RT_CONT);
  wire preset_nz  = (preset_q.hours != 10'h000) || (preset_q.mins != 6'h00);
  wire start_any  = i_start_key || (i_start_cmd && is_manual);
  wire can_start  = (st_q == ST_IDLE) || (st_q == ST_HOLD);
  wire e_harm     = i_harm_active && ((start_any && can_start) ||
                    (i_stop_req && (st_q == ST_RUN || st_q == ST_ARMED)));
  wire e_fast     = start_any && can_start && (i_rate_sel == RATE_FASTEST);
  wire e_zero     = start_any && can_start && (i_mode == EIC_RT_CONT) && !preset_nz;
  wire e_order    = start_any && can_start && is_rt && (i_sched_stop < i_sched_start);
  wire start_ok   = start_any && can_start && !i_harm_active && !e_fast && !e_zero && !e_order;
  wire stop_ok    = i_stop_req && !i_harm_active;

  wire ovf        = (acc_q[SUM_POS_E] >= ACC_LIMIT) || (acc_q[SUM_NEG_E] >= ACC_LIMIT) ||
                    (acc_q[SUM_POS_C] >= ACC_LIMIT) || (acc_q[SUM_NEG_C] >= ACC_LIMIT);
  wire time_max   = (elapsed.hours == HOURS_MAX) && (elapsed.mins == MINS_MAX);
  wire preset_hit = preset_nz && (elapsed.hours == preset_q.hours) &&
                    (elapsed.mins == preset_q.mins) && (elapsed.secs == 6'h00);
  wire sched_on   = (i_rtc_now >= i_sched_start);
  wire sched_end  = is_rt && (i_rtc_now >= i_sched_stop);
  // Repeat modes restart at the preset; standard modes stop there, manual ignores it
  wire stop_hit   = ovf || time_max || sched_end || (preset_hit && !is_repeat && !is_manual);
  wire running    = (st_q == ST_RUN);
  wire restart    = running && !stop_hit && !stop_ok && is_repeat && preset_hit;
  wire clear_all  = i_reset_cmd || restart;
  wire accum_on   = running && !stop_hit && !ovf;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE, ST_HOLD: begin
        if (start_ok) begin
          st_d = is_rt ? ST_ARMED : ST_RUN;
        end
      end
      ST_ARMED: begin
        if (stop_ok) begin
          st_d = ST_IDLE;
        end else if (sched_on) begin
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (stop_ok || stop_hit) begin
          st_d = ST_HOLD;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    if (i_reset_cmd) begin
      st_d = ST_IDLE;
    end
  end

  assign err_d.harm_busy   = e_harm;
  assign err_d.rate_busy   = i_rate_change_req && running;
  assign err_d.rate_fast   = e_fast && !i_harm_active;
  assign err_d.zero_preset = e_zero && !i_harm_active;
  assign err_d.sched_order = e_order && !i_harm_active;

  // Status flags taken from the next state so every output leaves a flop
  wire run_d   = (st_d == ST_RUN);
  wire hold_d  = (st_d == ST_HOLD);
  wire armed_d = (st_d == ST_ARMED);

  // ----------------------------------------------------------------
  // Sum inputs
  // ----------------------------------------------------------------
  wire signed [31:0] prod    = i_sample.volt * i_sample.curr;
  wire               v_pos   = !i_sample.volt[15] && (i_sample.volt != 16'h0000);
  wire               c_pos   = !i_sample.curr[15] && (i_sample.curr != 16'h0000);
  wire               v_neg   = i_sample.volt[15];
  wire               c_neg   = i_sample.curr[15];
  wire signed [16:0] c_wide  = {i_sample.curr[15], i_sample.curr};
  wire        [16:0] c_mag   = c_neg ? 17'(-c_wide) : 17'(c_wide);
  wire               dc_mode = (i_cmode == EIC_DC);
  wire               smp     = accum_on && i_sample.valid;

  assign add_val[SUM_POS_E] = ACC_W'(unsigned'(prod));
  assign add_val[SUM_NEG_E] = ACC_W'(unsigned'(prod));
  assign add_val[SUM_POS_C] = dc_mode ? ACC_W'(c_mag) : ACC_W'(i_curr_meas);
  assign add_val[SUM_NEG_C] = ACC_W'(c_mag);
  assign add_en[SUM_POS_E]  = smp && v_pos && c_pos;
  assign add_en[SUM_NEG_E]  = smp && v_neg && c_neg;
  assign add_en[SUM_POS_C]  = dc_mode ? (smp && c_pos) : (accum_on && i_update_valid);
  assign add_en[SUM_NEG_C]  = dc_mode && smp && c_neg;

  // ----------------------------------------------------------------
  // Accumulators
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SUMS; gi++) begin : g_sum
      always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          acc_q[gi] <= '0;
        end else if (clear_all) begin
          acc_q[gi] <= '0;
        end else if (add_en[gi]) begin
          acc_q[gi] <= acc_q[gi] + add_val[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q     <= ST_IDLE;
      preset_q <= '0;
      err_q    <= '0;
      run_q    <= 1'b0;
      hold_q   <= 1'b0;
      armed_q  <= 1'b0;
    end else begin
      st_q     <= st_d;
      preset_q <= preset_d;
      err_q    <= err_d;
      run_q    <= run_d;
      hold_q   <= hold_d;
      armed_q  <= armed_d;
    end
  end

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  eic_elapsed #(
    .SEC_CNT (SEC_CNT)
  ) u_elapsed (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_run   (accum_on),
    .i_clear (clear_all),
    .o_time  (elapsed)
  );

  eic_cursor u_cursor (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_left  (i_cur_left),
    .i_right (i_cur_right),
    .o_pos   (o_cursor)
  );

  assign o_running          = run_q;
  assign o_holding          = hold_q;
  assign o_armed            = armed_q;
  assign o_rate_locked      = run_q;
  assign o_elapsed          = elapsed;
  assign o_preset           = preset_q;
  assign o_pos_energy_total = acc_q[SUM_POS_E];
  assign o_neg_energy_total = acc_q[SUM_NEG_E];
  assign o_pos_charge_total = acc_q[SUM_POS_C];
  assign o_neg_charge_total = acc_q[SUM_NEG_C];
  assign o_err              = err_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  property p_manual_ceiling;
    running && is_manual && time_max && !i_reset_cmd |=> o_holding;
  endproperty
  a_manual_ceiling: assert property (p_manual_ceiling) else $error("manual not held at time ceiling");

  property p_hold_frozen;
    o_holding && !start_ok && !i_reset_cmd |=> $stable(o_elapsed) && $stable(o_pos_energy_total);
  endproperty
  a_hold_frozen: assert property (p_hold_frozen) else $error("held results changed");

  property p_std_preset;
    running && (i_mode == EIC_STANDARD) && preset_hit && !i_reset_cmd |=> o_holding;
  endproperty
  a_std_preset: assert property (p_std_preset) else $error("standard mode ran past preset");

  property p_cont_restart;
    restart && !i_reset_cmd |=> o_running && (o_elapsed == '0) && (o_pos_energy_total == '0);
  endproperty
  a_cont_restart: assert property (p_cont_restart) else $error("repeat did not clear and restart");

  property p_harm_refuse;
    i_harm_active && start_any && (st_q == ST_IDLE) && !i_reset_cmd |=> o_err.harm_busy && !o_running;
  endproperty
  a_harm_refuse: assert property (p_harm_refuse) else $error("start accepted during harmonics");

  property p_rate_busy;
    o_running && i_rate_change_req |=> o_err.rate_busy;
  endproperty
  a_rate_busy: assert property (p_rate_busy) else $error("rate change not refused");

  property p_rate_fast;
    start_any && can_start && !i_harm_active && (i_rate_sel == RATE_FASTEST) && !i_reset_cmd
      |=> o_err.rate_fast && !o_running && !o_armed;
  endproperty
  a_rate_fast: assert property (p_rate_fast) else $error("start at fastest rate accepted");

  property p_neg_split;
    smp && v_neg && c_pos && !clear_all |=> $stable(o_neg_energy_total);
  endproperty
  a_neg_split: assert property (p_neg_split) else $error("mixed polarity reached negative sum");

  property p_zero_preset;
    (st_q == ST_IDLE) && start_any && (i_mode == EIC_RT_CONT) && !preset_nz && !i_harm_active
      && !i_reset_cmd |=> o_err.zero_preset && !o_armed;
  endproperty
  a_zero_preset: assert property (p_zero_preset) else $error("zero preset repeat start accepted");

  property p_reset_clear;
    i_reset_cmd |=> !o_running && (o_pos_charge_total == '0) && (o_elapsed == '0);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left state behind");

  property p_idle_frozen;
    !o_running && !clear_all |=> $stable(o_elapsed);
  endproperty
  a_idle_frozen: assert property (p_idle_frozen) else $error("elapsed time moved while stopped");

  property p_value_ceiling;
    running && ovf && !i_reset_cmd |=> o_holding && !o_running;
  endproperty
  a_value_ceiling: assert property (p_value_ceiling) else $error("value ceiling did not stop and hold");

  property p_rt_preset;
    running && (i_mode == EIC_RT_STD) && preset_hit && !i_reset_cmd |=> o_holding;
  endproperty
  a_rt_preset: assert property (p_rt_preset) else $error("scheduled run passed its preset");

  property p_rt_restart;
    running && (i_mode == EIC_RT_CONT) && preset_hit && !ovf && !time_max && !sched_end && !i_stop_req
      && !i_reset_cmd |=> o_running && (o_elapsed == '0);
  endproperty
  a_rt_restart: assert property (p_rt_restart) else $error("scheduled repeat did not restart");

  property p_pos_split;
    smp && v_pos && c_neg && !clear_all |=> $stable(o_pos_energy_total);
  endproperty
  a_pos_split: assert property (p_pos_split) else $error("mixed polarity reached positive sum");

  property p_dc_charge;
    smp && dc_mode && c_neg && !clear_all |=> $stable(o_pos_charge_total);
  endproperty
  a_dc_charge: assert property (p_dc_charge) else $error("negative current reached positive charge");

  property p_sched_order;
    start_any && can_start && is_rt && (i_sched_stop < i_sched_start) && !i_harm_active && !i_reset_cmd
      |=> o_err.sched_order && !o_armed && !o_running;
  endproperty
  a_sched_order: assert property (p_sched_order) else $error("stop before start accepted");

  c_run_to_hold: cover property (o_running ##1 o_holding);
  c_restart:     cover property (restart);
  c_armed_run:   cover property (o_armed ##1 o_running);
  c_ovf:         cover property (running && ovf);

endmodule

//--- rtl/eic_pkg.sv
// Shared types and constants of the energy integration controller
package eic_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int SEC_NS        = 32'h3B9A_CA00;  // One second in ns
  localparam int SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Limits and widths
  // ----------------------------------------------------------------
  localparam int          ACC_W     = 48;
  localparam int          NUM_SUMS  = 4;
  localparam logic [47:0] ACC_LIMIT = 48'h0000_E8D4_A510;  // Ceiling in raw sum units
  localparam logic [9:0]  HOURS_MAX = 10'h3E7;
  localparam logic [5:0]  MINS_MAX  = 6'h3B;
  localparam logic [5:0]  SECS_MAX  = 6'h3B;
  localparam logic [1:0]  RATE_FASTEST = 2'h0;              // 100 ms setting
  localparam logic [2:0]  CURSOR_LAST  = 3'h4;              // Five digits hhhmm
  localparam int          SUM_POS_E = 0;
  localparam int          SUM_NEG_E = 1;
  localparam int          SUM_POS_C = 2;
  localparam int          SUM_NEG_C = 3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    EIC_MANUAL, EIC_STANDARD, EIC_CONT, EIC_RT_STD, EIC_RT_CONT
  } eic_mode_t;

  typedef enum logic [1:0] {EIC_RMS, EIC_MEAN, EIC_DC} eic_cmode_t;

  typedef struct packed {
    logic [9:0] hours;
    logic [5:0] mins;
    logic [5:0] secs;
  } eic_time_t;

  typedef struct packed {
    logic [9:0] hours;
    logic [5:0] mins;
  } eic_preset_t;

  typedef struct packed {
    logic               valid;
    logic signed [15:0] volt;
    logic signed [15:0] curr;
  } eic_sample_t;

  typedef struct packed {
    logic harm_busy;    // Start or stop refused during harmonic analysis
    logic rate_busy;    // Update rate change refused while running
    logic rate_fast;    // Start refused at fastest update rate
    logic zero_preset;  // Scheduled repeat start with zero preset
    logic sched_order;  // Stop time earlier than start time
  } eic_err_t;

endpackage

//--- rtl/eic_cursor.sv
// Digit cursor for editing time, date and timer values
`timescale 1ns/1ps
module eic_cursor
  import eic_pkg::*;
(
  input  wire logic       i_mclk,   // Clock
  input  wire logic       i_rst_n,  // Async reset, active low
  input  wire logic       i_left,   // Move cursor left
  input  wire logic       i_right,  // Move cursor right
  output logic [2:0]      o_pos     // Cursor digit, 0 is leftmost
);

  logic [2:0] pos_d;
  logic [2:0] pos_q;

  // Both keys together leave the cursor where it is
  assign pos_d = (i_left && !i_right) ? ((pos_q == 3'h0) ? CURSOR_LAST : pos_q - 3'h1) :
                 (i_right && !i_left) ? ((pos_q == CURSOR_LAST) ? 3'h0 : pos_q + 3'h1) :
                 pos_q;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pos_q <= 3'h0;
    end else begin
      pos_q <= pos_d;
    end
  end

  assign o_pos = pos_q;

endmodule

//--- rtl/eic_elapsed.sv
// Elapsed integration time counter, hours minutes seconds
`timescale 1ns/1ps
module eic_elapsed
  import eic_pkg::*;
#(
  parameter int SEC_CNT = SEC_CYCLES
) (
  input  wire logic i_mclk,   // Clock
  input  wire logic i_rst_n,  // Async reset, active low
  input  wire logic i_run,    // Count while high
  input  wire logic i_clear,  // Zero the count, wins over run
  output eic_time_t o_time    // Elapsed time
);

  logic [31:0] pre_q;
  logic [31:0] pre_d;
  eic_time_t   t_q;
  eic_time_t   t_d;
  logic        tick;
  logic        sec_wrap;
  logic        min_wrap;

  assign tick     = i_run && (pre_q == 32'(SEC_CNT - 1));
  assign sec_wrap = (t_q.secs == SECS_MAX);
  assign min_wrap = sec_wrap && (t_q.mins == MINS_MAX);
  assign pre_d    = (i_clear || !i_run || tick) ? 32'h0000_0000 : pre_q + 32'h0000_0001;

  // Frozen unless running; the controller stops before hours pass the ceiling
  assign t_d.secs  = i_clear ? 6'h00 : !tick ? t_q.secs : sec_wrap ? 6'h00 : t_q.secs + 6'h01;
  assign t_d.mins  = i_clear ? 6'h00 : !(tick && sec_wrap) ? t_q.mins :
                     min_wrap ? 6'h00 : t_q.mins + 6'h01;
  assign t_d.hours = i_clear ? 10'h000 : (tick && min_wrap) ? t_q.hours + 10'h001 : t_q.hours;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_q <= 32'h0000_0000;
      t_q   <= '0;
    end else begin
      pre_q <= pre_d;
      t_q   <= t_d;
    end
  end

  assign o_time = t_q;

endmodule

//--- tb/eic_operator.sv
// Operator keys and remote command model driving the integration controller
`timescale 1ns/1ps
module eic_operator
  import eic_pkg::*;
(
  input  wire logic   i_mclk,   // Clock
  output logic [5:0]  o_keys,   // {start,remote,stop,reset,left,right}
  output eic_preset_t o_preset  // Programmed timer preset
);
  initial begin
    o_keys   = 6'h00;
    o_preset = 16'h0000;
  end

  // One-cycle pulse, raised and dropped on rising edges like a debounced key
  task automatic press(input logic [5:0] k);
    @(posedge i_mclk);
    o_keys <= k;
    @(posedge i_mclk);
    o_keys <= 6'h00;
  endtask

  // Operator keeps the preset at zero before manual runs
  task automatic set_preset(input logic [9:0] h, input logic [5:0] m);
    @(posedge i_mclk);
    o_preset <= {h, m};
  endtask
endmodule

//--- tb/test_eic_ctrl.sv
// Self-checking testbench of the integration controller
`timescale 1ns/1ps
module test_eic_ctrl
  import eic_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b0, harm = 1'b0, rate_req = 1'b0, upd = 1'b0;
  eic_mode_t   mode = EIC_MANUAL;
  eic_cmode_t  cmode = EIC_DC;
  logic [31:0] rtc = 32'h0000_0000, s_start = 32'h0000_0000, s_stop = 32'h0000_0000;
  logic [1:0]  rate = 2'h1;
  eic_sample_t smp = 33'h0_0000_0000;
  logic [5:0]  keys;
  eic_preset_t preset, o_pre;
  logic        run, hold, armed, lock;
  logic [15:0] meas = 16'h0000;
  eic_time_t   el, e0;
  logic [47:0] pe, ne, pc, nc;
  eic_err_t    err;
  logic [2:0]  cur;
  int          bad_count = 0, tests_run = 0;

  always #12.5 clk = ~clk;

  eic_operator u_eic_operator (.i_mclk(clk), .o_keys(keys), .o_preset(preset));

  eic_ctrl #(.SEC_CNT(4)) u_eic_ctrl (
    .i_mclk(clk), .i_rst_n(rst_n), .i_start_key(keys[5]), .i_start_cmd(keys[4]),
    .i_stop_req(keys[3]), .i_reset_cmd(keys[2]), .i_mode(mode), .i_preset(preset),
    .i_rtc_now(rtc), .i_sched_start(s_start), .i_sched_stop(s_stop), .i_harm_active(harm),
    .i_rate_sel(rate), .i_rate_change_req(rate_req), .i_sample(smp), .i_cmode(cmode),
    .i_update_valid(upd), .i_curr_meas(meas), .i_cur_left(keys[1]), .i_cur_right(keys[0]),
    .o_running(run), .o_holding(hold), .o_armed(armed), .o_rate_locked(lock), .o_elapsed(el),
    .o_preset(o_pre), .o_pos_energy_total(pe), .o_neg_energy_total(ne),
    .o_pos_charge_total(pc), .o_neg_charge_total(nc), .o_err(err), .o_cursor(cur));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Key press, then look in the cycle right after the edge that took it
  task automatic key(input logic [5:0] k);
    u_eic_operator.press(k);
    @(negedge clk);
  endtask

  task automatic samp(input logic signed [15:0] v, input logic signed [15:0] i);
    @(posedge clk);
    smp <= {1'b1, v, i};
    @(posedge clk);
    smp.valid <= 1'b0;
    @(negedge clk);
  endtask

  task automatic wait_hold(input int lim);
    int n;
    n = 0;
    while (hold !== 1'b1) begin
      @(negedge clk);
      if (++n > lim) begin
        bad_count++;
        tally_and_finish();
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_manual();
    key(6'h10);
    chk(48'(run), 48'h1);
    samp(16'sd2, 16'sd3);
    samp(-16'sd2, -16'sd3);
    samp(16'sd5, -16'sd4);
    chk(pe, 48'h6);
    chk(ne, 48'h6);
    chk(pc, 48'h3);
    chk(nc, 48'h7);
    @(posedge clk);
    rate_req <= 1'b1;
    @(posedge clk);
    rate_req <= 1'b0;
    @(negedge clk);
    chk(48'(err), 48'h8);
    chk(48'(lock), 48'h1);
    repeat (40) @(negedge clk);
    key(6'h08);
    chk(48'({run, hold}), 48'h1);
    e0 = el;
    chk(48'(e0.secs != 6'h00), 48'h1);
    repeat (20) @(negedge clk);
    chk(48'(el), 48'(e0));
    chk(pe, 48'h6);
    $display("test manual done");
  endtask

  task automatic t_refuse();
    key(6'h04);
    chk({pe[11:0], ne[11:0], pc[11:0], nc[11:0]}, 48'h0);
    chk(48'({el, run, hold}), 48'h0);
    @(posedge clk);
    rate <= 2'h0;
    key(6'h20);
    chk(48'({err, run}), 48'h08);
    @(posedge clk);
    rate <= 2'h1;
    harm <= 1'b1;
    key(6'h20);
    chk(48'({err, run}), 48'h20);
    u_eic_operator.set_preset(10'h3FF, 6'h3F);
    harm <= 1'b0;
    repeat (2) @(negedge clk);
    chk(48'(o_pre), 48'({10'h3E7, 6'h3B}));
    $display("test refuse done");
  endtask

  task automatic t_timer();
    u_eic_operator.set_preset(10'h000, 6'h01);
    mode <= EIC_STANDARD;
    key(6'h20);
    chk(48'(run), 48'h1);
    wait_hold(400);
    chk(48'(el), 48'({10'h000, 6'h01, 6'h00}));
    key(6'h04);
    @(posedge clk);
    mode <= EIC_CONT;
    key(6'h20);
    repeat (300) @(negedge clk);
    chk(48'({run, el.mins}), 48'h40);
    key(6'h08);
    $display("test timer done");
  endtask

  task automatic t_sched();
    key(6'h04);
    u_eic_operator.set_preset(10'h000, 6'h00);
    mode <= EIC_RT_CONT;
    key(6'h20);
    chk(48'(err), 48'h2);
    @(posedge clk);
    mode <= EIC_RT_STD;
    s_start <= 32'h0000_0064;
    s_stop <= 32'h0000_0032;
    key(6'h20);
    chk(48'({err, armed}), 48'h2);
    @(posedge clk);
    s_stop <= 32'h0000_00C8;
    key(6'h20);
    chk(48'({armed, run}), 48'h2);
    @(posedge clk);
    rtc <= 32'h0000_0096;
    repeat (3) @(negedge clk);
    chk(48'(run), 48'h1);
    @(posedge clk);
    rtc <= 32'h0000_00FA;
    repeat (3) @(negedge clk);
    chk(48'({run, hold}), 48'h1);
    key(6'h02);
    chk(48'(cur), 48'h4);
    key(6'h01);
    chk(48'(cur), 48'h0);
    $display("test sched done");
  endtask

  task automatic t_rt();
    key(6'h04);
    u_eic_operator.set_preset(10'h000, 6'h01);
    mode <= EIC_RT_STD;
    rtc <= 32'h0000_0000;
    key(6'h20);
    @(posedge clk);
    rtc <= 32'h0000_0096;
    wait_hold(400);
    chk(48'(el), 48'({10'h000, 6'h01, 6'h00}));
    key(6'h04);
    @(posedge clk);
    mode <= EIC_RT_CONT;
    rtc <= 32'h0000_0000;
    key(6'h20);
    @(posedge clk);
    rtc <= 32'h0000_0096;
    repeat (300) @(negedge clk);
    chk(48'({run, el.mins}), 48'h40);
    @(posedge clk);
    rtc <= 32'h0000_00FA;
    repeat (3) @(negedge clk);
    chk(48'({run, hold}), 48'h1);
    $display("test scheduled repeat done");
  endtask

  task automatic t_rms();
    key(6'h04);
    u_eic_operator.set_preset(10'h000, 6'h00);
    mode  <= EIC_MANUAL;
    cmode <= EIC_RMS;
    meas  <= 16'h0010;
    key(6'h20);
    samp(16'sh0002, 16'sh0003);
    @(posedge clk);
    upd <= 1'b1;
    @(posedge clk);
    upd <= 1'b0;
    @(negedge clk);
    chk(pe, 48'h6);
    chk(pc, 48'h10);
    key(6'h08);
    $display("test rms done");
  endtask

  task automatic t_ovf();
    key(6'h04);
    u_eic_operator.set_preset(10'h001, 6'h00);
    mode <= EIC_CONT;
    key(6'h20);
    @(posedge clk);
    smp <= {1'b1, 16'sh7FFF, 16'sh7FFF};
    wait_hold(1200);
    e0 = el;
    @(posedge clk);
    smp.valid <= 1'b0;
    repeat (8) @(negedge clk);
    chk(48'({run, hold}), 48'h1);
    chk(48'(pe >= ACC_LIMIT), 48'h1);
    chk(48'(el), 48'(e0));
    $display("test overflow done");
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_manual();
    t_refuse();
    t_timer();
    t_sched();
    t_rt();
    t_rms();
    t_ovf();
    tally_and_finish();
  end
endmodule
